// ==== inc/iesq_pkg.sv ====
package iesq_pkg;

  // APB register byte offsets
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_FLAG  = 12'h004;
  localparam logic [11:0] ADDR_FSAVE = 12'h008;
  localparam logic [11:0] ADDR_PSAVE = 12'h00C;
  localparam logic [11:0] ADDR_STAT  = 12'h010;
  localparam logic [11:0] ADDR_WAITS = 12'h014;

  // Control register fields
  localparam int CTRL_PPL_LSB   = 0;
  localparam int CTRL_BUS8      = 3;
  localparam int CTRL_DMEM      = 4;
  localparam int CTRL_DMODE_LSB = 5;
  localparam int CTRL_DDBL      = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Flag word fields
  localparam int FLAG_D_BIT = 2;
  localparam int FLAG_U_BIT = 5;
  localparam int FLAG_I_BIT = 6;
  localparam logic [15:0] FLAG_RESET = 16'h0000;

  // Status register fields
  localparam int STAT_BUSY     = 0;
  localparam int STAT_OVERWAIT = 1;
  localparam int STAT_LAT_LSB  = 8;

  // Interrupt information addresses
  localparam logic [23:0] INFO_ADDR_NORMAL = 24'h00_0000;
  localparam logic [23:0] INFO_ADDR_FAST   = 24'h00_0002;

  localparam logic [2:0] PPL_MAX     = 3'h7;
  localparam logic [2:0] PPL_NMI_WDT = 3'h7;
  localparam logic [5:0] SWINT_KEEP_LO = 6'h20;
  localparam logic [5:0] SWINT_KEEP_HI = 6'h3F;

  // Entry sequence lengths in cycles
  localparam logic [4:0] CYC_FAST      = 5'h05;
  localparam logic [4:0] CYC_SWINT_E16 = 5'h0C;
  localparam logic [4:0] CYC_SWINT_OTH = 5'h0E;
  localparam logic [4:0] CYC_PERI_E16  = 5'h0E;
  localparam logic [4:0] CYC_PERI_OTH  = 5'h10;
  localparam logic [4:0] CYC_FIX_16    = 5'h0D;
  localparam logic [4:0] CYC_FIX_8     = 5'h0F;
  localparam logic [4:0] CYC_OVF_16    = 5'h0E;
  localparam logic [4:0] CYC_OVF_8     = 5'h10;
  localparam logic [4:0] CYC_BRKV_E16  = 5'h11;
  localparam logic [4:0] CYC_BRKV_OTH  = 5'h13;
  localparam logic [4:0] CYC_DBG_16    = 5'h13;
  localparam logic [4:0] CYC_DBG_8     = 5'h15;

  // Longest wait for an instruction boundary
  localparam logic [7:0] DIV_BASE    = 8'h18;
  localparam logic [7:0] DIV_ADD_NRM = 8'h02;
  localparam logic [7:0] DIV_ADD_IDX = 8'h03;
  localparam logic [7:0] DIV_ADD_IND = 8'h05;
  localparam logic [7:0] DIV_ADD_IIX = 8'h06;

  typedef enum logic [3:0] {
    IESQ_PERI  = 4'h0,
    IESQ_SWINT = 4'h1,
    IESQ_NMI   = 4'h2,
    IESQ_WDT   = 4'h3,
    IESQ_UNDEF = 4'h4,
    IESQ_ADDRM = 4'h5,
    IESQ_OVF   = 4'h6,
    IESQ_BRKV  = 4'h7,
    IESQ_SSTEP = 4'h8,
    IESQ_BREAK2 = 4'h9,
    IESQ_BRKF  = 4'hA
  } iesq_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INFO = 3'b001,
    ST_TEMP = 3'b011,
    ST_SFLG = 3'b010,
    ST_SPC  = 3'b110,
    ST_PPL  = 3'b111,
    ST_WAIT = 3'b101
  } iesq_state_t;

  typedef struct packed {
    iesq_kind_t kind;
    logic [5:0] num;
    logic       odd;
  } iesq_src_t;

  typedef struct packed {
    logic       pend;
    logic [2:0] level;
    logic       fast;
    logic       odd;
  } iesq_mreq_t;

endpackage

// ==== rtl/iesq_gate.sv ====
`timescale 1ns/10ps
`default_nettype none
module iesq_gate
  import iesq_pkg::*;
(
  input  wire logic [2:0] ppl,
  input  wire logic       ien,
  input  wire logic       pend,
  input  wire logic [2:0] level,
  output logic            enabled
);

  // Level 0 never exceeds ppl, and ppl at its maximum blocks everything
  always_comb begin
    enabled = ien && pend && (level > ppl) && (ppl != PPL_MAX);
  end

endmodule // iesq_gate
`default_nettype wire

// ==== rtl/iesq_cnt.sv ====
`timescale 1ns/10ps
`default_nettype none
module iesq_cnt #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] cnt,
  output logic              last
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign last = (cnt == W'(1));

endmodule // iesq_cnt
`default_nettype wire

// ==== rtl/iesq_seq.sv ====
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - ppl n from 0 to 6 enables maskable levels n+1 and above only
// - ppl at seven blocks every maskable request
// - Request mid-instruction is taken at the boundary, sequence starts next cycle
// - String and repeat instructions are suspended for a pending request
// - First step reads info at 000000 or 000002 and clears the request in the same cycle
// - Second step copies the pre-sequence flag word into a hidden register
// - Second step also clears I, D, U; U kept for software numbers 32 to 63
// - Third step stores the flag copy to stack or flag_save_reg
// - Fourth step stores the program counter to stack or pc_save_reg
// - Fifth step loads ppl with the accepted level (7 for NMI and watchdog), then fetch starts
// - Boundary wait bound is 24 cycles for register divisor
// - Memory divisor adds 2+X, 3+X, 5+X+2Y or 6+X+2Y cycles
// - Peripheral 14 or 16 cycles, software interrupt 12 or 14 cycles
// - Fixed sources 13 or 15 cycles; overflow 14 or 16 cycles
// - Variable-table break takes 17 cycles, otherwise 19
// - Single step and fixed breaks take 19 or 21 cycles
// - High-speed interrupt takes 5 cycles always
// - Maskable accepted only with I set, request set, level above ppl
module iesq_seq
  import iesq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire iesq_mreq_t  mreq,
  output logic             mreq_clear,
  input  wire logic        src_pend,
  input  wire iesq_src_t   src,
  output logic             src_ack,
  input  wire logic        insn_done,
  input  wire logic        insn_string,
  output logic             insn_suspend,
  input  wire logic [31:0] pc,
  output logic             info_rd,
  output logic      [23:0] info_addr,
  output logic             push_valid,
  output logic      [31:0] push_data,
  output logic             fetch_start,
  output logic             fetch_fast,
  output logic             busy
);

  iesq_state_t st;
  logic [7:0]  ctrl;
  logic [15:0] flag_word;
  logic [15:0] tmp_flag;
  logic [15:0] flag_save_reg;
  logic [31:0] pc_save_reg;
  logic [7:0]  waits;
  logic [7:0]  latency;
  logic [7:0]  lat_seen;
  logic        over_wait;
  iesq_kind_t  cur_kind;
  logic [5:0]  cur_num;
  logic [2:0]  cur_level;
  logic        cur_fast;
  logic        mask_ok;
  logic        hi_src;
  logic        any_req;
  logic        go;
  logic        take_mask;
  logic        take_src;
  logic        seq_load;
  logic [4:0]  seq_len;
  logic        seq_last;
  logic        apb_wr;
  logic        apb_setup;
  logic [7:0]  div_bound;

  function automatic logic [4:0] entry_cycles(input iesq_kind_t k, input logic fast,
                                              input logic odd, input logic bus8);
    logic e16;
    e16 = !odd && !bus8;
    if (fast) begin
      entry_cycles = CYC_FAST;
    end else begin
      case (k)
        IESQ_PERI:  entry_cycles = e16 ? CYC_PERI_E16 : CYC_PERI_OTH;
        IESQ_SWINT: entry_cycles = e16 ? CYC_SWINT_E16 : CYC_SWINT_OTH;
        IESQ_OVF:   entry_cycles = bus8 ? CYC_OVF_8 : CYC_OVF_16;
        IESQ_BRKV:  entry_cycles = e16 ? CYC_BRKV_E16 : CYC_BRKV_OTH;
        IESQ_SSTEP, IESQ_BREAK2, IESQ_BRKF: begin
          entry_cycles = bus8 ? CYC_DBG_8 : CYC_DBG_16;
        end
        default:    entry_cycles = bus8 ? CYC_FIX_8 : CYC_FIX_16;
      endcase
    end
  endfunction

  // Doubling covers odd addresses and 8-bit bus areas alike
  function automatic logic [7:0] div_limit(input logic [7:0] c, input logic [7:0] w);
    logic [7:0] x;
    logic [7:0] y;
    x = c[CTRL_DDBL] ? {3'h0, w[3:0], 1'b0} : {4'h0, w[3:0]};
    y = c[CTRL_DDBL] ? {3'h0, w[7:4], 1'b0} : {4'h0, w[7:4]};
    if (!c[CTRL_DMEM]) begin
      div_limit = DIV_BASE;
    end else begin
      case (c[CTRL_DMODE_LSB +: 2])
        2'h0:    div_limit = DIV_BASE + DIV_ADD_NRM + x;
        2'h1:    div_limit = DIV_BASE + DIV_ADD_IDX + x;
        2'h2:    div_limit = DIV_BASE + DIV_ADD_IND + x + {y[6:0], 1'b0};
        default: div_limit = DIV_BASE + DIV_ADD_IIX + x + {y[6:0], 1'b0};
      endcase
    end
  endfunction

  iesq_gate u_gate (
    .ppl     (ctrl[CTRL_PPL_LSB +: 3]),
    .ien     (flag_word[FLAG_I_BIT]),
    .pend    (mreq.pend),
    .level   (mreq.level),
    .enabled (mask_ok)
  );

  iesq_cnt #(.W(5)) u_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (seq_load),
    .load_val (seq_len),
    .cnt      (),
    .last     (seq_last)
  );

  // Hardware-fixed order: NMI, watchdog and instruction traps ahead of
  // peripherals; single step and address match behind them
  assign hi_src    = src_pend && (src.kind != IESQ_SSTEP) && (src.kind != IESQ_ADDRM);
  assign any_req   = mask_ok || src_pend;
  assign go        = (st == ST_IDLE) && any_req && (insn_done || insn_string);
  assign take_src  = go && (hi_src || !mask_ok);
  assign take_mask = go && !take_src;
  assign seq_load  = go;
  assign seq_len   = take_mask ? entry_cycles(IESQ_PERI, mreq.fast, mreq.odd, ctrl[CTRL_BUS8])
                               : entry_cycles(src.kind, 1'b0, src.odd, ctrl[CTRL_BUS8]);
  assign apb_setup  = psel && !penable;
  assign apb_wr     = psel && penable && pready && pwrite;
  assign div_bound  = div_limit(ctrl, waits);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: st <= go ? ST_INFO : ST_IDLE;
        ST_INFO: st <= ST_TEMP;
        ST_TEMP: st <= ST_SFLG;
        ST_SFLG: st <= ST_SPC;
        ST_SPC:  st <= ST_PPL;
        ST_PPL:  st <= seq_last ? ST_IDLE : ST_WAIT;
        ST_WAIT: st <= seq_last ? ST_IDLE : ST_WAIT;
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_kind  <= IESQ_PERI;
      cur_num   <= '0;
      cur_level <= '0;
      cur_fast  <= 1'b0;
    end else if (go) begin
      cur_kind  <= take_mask ? IESQ_PERI : src.kind;
      cur_num   <= take_mask ? 6'h00 : src.num;
      cur_level <= take_mask ? mreq.level : ctrl[CTRL_PPL_LSB +: 3];
      cur_fast  <= take_mask && mreq.fast;
    end
  end

  // Entry handshakes toward sources, pipeline and memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info_rd      <= 1'b0;
      info_addr    <= INFO_ADDR_NORMAL;
      mreq_clear   <= 1'b0;
      src_ack      <= 1'b0;
      insn_suspend <= 1'b0;
      push_valid   <= 1'b0;
      push_data    <= '0;
      fetch_start  <= 1'b0;
      fetch_fast   <= 1'b0;
      busy         <= 1'b0;
    end else begin
      info_rd      <= go;
      mreq_clear   <= take_mask;
      src_ack      <= take_src;
      insn_suspend <= go && !insn_done;
      if (go) begin
        info_addr <= (take_mask && mreq.fast) ? INFO_ADDR_FAST : INFO_ADDR_NORMAL;
      end
      push_valid <= !cur_fast && ((st == ST_SFLG) || (st == ST_SPC));
      push_data  <= (st == ST_SFLG) ? {16'h0000, tmp_flag} : pc;
      fetch_start <= (st == ST_PPL || st == ST_WAIT) && seq_last;
      fetch_fast  <= (st == ST_PPL || st == ST_WAIT) && seq_last && cur_fast;
      busy        <= (st != ST_IDLE) ? !((st == ST_PPL || st == ST_WAIT) && seq_last) : go;
    end
  end

  // Flag word: hardware clearing during entry wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_word <= FLAG_RESET;
      tmp_flag  <= FLAG_RESET;
    end else if (st == ST_TEMP) begin
      tmp_flag <= flag_word;
      flag_word[FLAG_I_BIT] <= 1'b0;
      flag_word[FLAG_D_BIT] <= 1'b0;
      if (!(cur_kind == IESQ_SWINT && cur_num >= SWINT_KEEP_LO && cur_num <= SWINT_KEEP_HI)) begin
        flag_word[FLAG_U_BIT] <= 1'b0;
      end
    end else if (apb_wr && paddr == ADDR_FLAG) begin
      flag_word <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_save_reg <= '0;
      pc_save_reg   <= '0;
    end else begin
      if (st == ST_SFLG && cur_fast) begin
        flag_save_reg <= tmp_flag;
      end
      if (st == ST_SPC && cur_fast) begin
        pc_save_reg <= pc;
      end
    end
  end

  // Only level-bearing and NMI/watchdog sources move ppl
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= CTRL_RESET;
      waits <= '0;
    end else begin
      if (apb_wr && paddr == ADDR_CTRL) begin
        ctrl <= pwdata[7:0];
      end
      if (st == ST_PPL) begin
        if (cur_kind == IESQ_PERI) begin
          ctrl[CTRL_PPL_LSB +: 3] <= cur_level;
        end else if (cur_kind == IESQ_NMI || cur_kind == IESQ_WDT) begin
          ctrl[CTRL_PPL_LSB +: 3] <= PPL_NMI_WDT;
        end
      end
      if (apb_wr && paddr == ADDR_WAITS) begin
        waits <= pwdata[7:0];
      end
    end
  end

  // Boundary latency monitor; a late boundary sets a sticky flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latency   <= '0;
      lat_seen  <= '0;
      over_wait <= 1'b0;
    end else begin
      if (st != ST_IDLE || !any_req || go) begin
        latency <= '0;
      end else if (latency != 8'hFF) begin
        latency <= latency + 8'h01;
      end
      if (go) begin
        lat_seen <= latency;
      end
      if (st == ST_IDLE && any_req && latency > div_bound) begin
        over_wait <= 1'b1;
      end else if (apb_wr && paddr == ADDR_STAT && pwdata[STAT_OVERWAIT]) begin
        over_wait <= 1'b0;
      end
    end
  end

  // APB slave, zero wait states: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (apb_setup) begin
        case (paddr)
          ADDR_CTRL:  prdata <= {24'h00_0000, ctrl};
          ADDR_FLAG:  prdata <= {16'h0000, flag_word};
          ADDR_FSAVE: prdata <= {16'h0000, flag_save_reg};
          ADDR_PSAVE: prdata <= pc_save_reg;
          ADDR_STAT:  prdata <= {16'h0000, lat_seen, 6'h00, over_wait, st != ST_IDLE};
          ADDR_WAITS: prdata <= {24'h00_0000, waits};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // iesq_seq
`default_nettype wire

// ==== dv/iesq_pipe_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iesq_pipe_model
  import iesq_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       str,
  input  wire logic       stall,
  input  wire logic       mfire,
  input  wire iesq_mreq_t mset,
  input  wire logic       sfire,
  input  wire iesq_src_t  sset,
  input  wire logic       mreq_clear,
  input  wire logic       src_ack,
  output iesq_mreq_t      mreq,
  output logic            src_pend,
  output iesq_src_t       src,
  output logic            insn_done,
  output logic [31:0]     pc
);
  logic [1:0] ph;
  // String instructions never reach a boundary; insn_suspend is not seen here, the test ends them by dropping str
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 2'h0;
      insn_done <= 1'b0;
      pc <= 32'h0000_1000;
    end else begin
      ph <= ph + 2'h1;
      insn_done <= (ph == 2'h3) && !str && !stall;
      if (insn_done) begin
        pc <= pc + 32'h0000_0004;
      end
    end
  end
  // A request stays pending until the sequencer clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mreq <= '0;
    end else if (mfire) begin
      mreq <= mset;
    end else if (mreq_clear) begin
      mreq.pend <= 1'b0;
    end
  end
  // Vectors are even unless a case asks for odd
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_pend <= 1'b0;
      src <= '0;
    end else if (sfire) begin
      src_pend <= 1'b1;
      src <= sset;
    end else if (src_ack) begin
      src_pend <= 1'b0;
    end
  end
endmodule // iesq_pipe_model
`default_nettype wire

// ==== dv/iesq_seq_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module iesq_seq_sva
  import iesq_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire iesq_mreq_t  mreq,
  input wire logic        mreq_clear,
  input wire logic        src_ack,
  input wire logic        insn_done,
  input wire logic        insn_string,
  input wire logic        insn_suspend,
  input wire logic [31:0] pc,
  input wire logic        info_rd,
  input wire logic [23:0] info_addr,
  input wire logic        push_valid,
  input wire logic [31:0] push_data,
  input wire logic        fetch_start,
  input wire logic        fetch_fast,
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence push_s;
    ##3 push_valid ##1 (push_valid && push_data == $past(pc));
  endsequence
  sequence fast_s;
    ##5 (fetch_start && fetch_fast);
  endsequence
  info_addr_a: assert property (
    info_rd && mreq_clear |->
      info_addr == ($past(mreq.fast) ? INFO_ADDR_FAST : INFO_ADDR_NORMAL))
    else $error("info address wrong");
  src_info_a: assert property (
    src_ack |-> info_rd && info_addr == INFO_ADDR_NORMAL)
    else $error("source info read wrong");
  entry_start_a: assert property (
    $rose(busy) |-> info_rd && $past(insn_done || insn_string))
    else $error("entry off boundary");
  suspend_cause_a: assert property (
    insn_suspend |-> $past(insn_string) && !$past(insn_done))
    else $error("suspend without string");
  fast_len_a: assert property (
    info_rd && info_addr == INFO_ADDR_FAST |-> fast_s)
    else $error("fast entry length wrong");
  push_order_a: assert property (
    info_rd && info_addr == INFO_ADDR_NORMAL |-> push_s)
    else $error("push order wrong");
  no_resample_a: assert property (
    info_rd |-> ##1 (!info_rd && busy) [*4])
    else $error("resampled during entry");
  clear_cause_a: assert property (
    mreq_clear |-> $past(mreq.pend) && $past(mreq.level) != 3'h0)
    else $error("clear without request");
  fetch_end_a: assert property (
    fetch_start |-> !busy && $past(busy))
    else $error("fetch outside entry");
endmodule // iesq_seq_sva
bind iesq_seq iesq_seq_sva i_sva (.pclk(pclk), .presetn(presetn), .mreq(mreq),
  .mreq_clear(mreq_clear), .src_ack(src_ack), .insn_done(insn_done),
  .insn_string(insn_string), .insn_suspend(insn_suspend), .pc(pc), .info_rd(info_rd),
  .info_addr(info_addr), .push_valid(push_valid), .push_data(push_data),
  .fetch_start(fetch_start), .fetch_fast(fetch_fast), .busy(busy));
`default_nettype wire

// ==== dv/interrupt_entry_sequencer_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module interrupt_entry_sequencer_test
  import iesq_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        str = 1'b0;
  logic        mfire = 1'b0;
  logic        sfire = 1'b0;
  logic        stall = 1'b0;
  iesq_mreq_t  mset = '0;
  iesq_src_t   sset = '0;
  logic [31:0] prdata, pc, push_data, rd;
  logic [23:0] info_addr;
  iesq_mreq_t  mreq;
  iesq_src_t   src;
  logic pready, pslverr, mreq_clear, src_pend, src_ack, insn_done, insn_suspend;
  logic info_rd, push_valid, fetch_start, fetch_fast, busy, er, ff, sp;
  int   fail_count = 0;
  int   samples_checked = 0;
  int   n;
  iesq_seq i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mreq(mreq), .mreq_clear(mreq_clear),
    .src_pend(src_pend), .src(src), .src_ack(src_ack), .insn_done(insn_done),
    .insn_string(str), .insn_suspend(insn_suspend), .pc(pc), .info_rd(info_rd),
    .info_addr(info_addr), .push_valid(push_valid), .push_data(push_data),
    .fetch_start(fetch_start), .fetch_fast(fetch_fast), .busy(busy));
  iesq_pipe_model i_pipe (.pclk(pclk), .presetn(presetn), .str(str), .stall(stall),
    .mfire(mfire),
    .mset(mset), .sfire(sfire), .sset(sset), .mreq_clear(mreq_clear),
    .src_ack(src_ack), .mreq(mreq), .src_pend(src_pend), .src(src),
    .insn_done(insn_done), .pc(pc));
  always #2 pclk = ~pclk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task timeout;
    check(32'h0000_0000, 32'h0000_0001);
    stop_test;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task mreq_go(input logic pd, input logic [2:0] lv, input logic fs);
    @(posedge pclk);
    mset <= '{pd, lv, fs, 1'b0};
    mfire <= 1'b1;
    @(posedge pclk);
    mfire <= 1'b0;
  endtask
  task src_go(input iesq_kind_t k, input logic [5:0] nm, input logic od);
    @(posedge pclk);
    sset <= '{k, nm, od};
    sfire <= 1'b1;
    @(posedge pclk);
    sfire <= 1'b0;
  endtask
  // Counts from the info read cycle to the fetch cycle, which is the entry length
  task entry;
    int i;
    for (i = 0; i < 60 && busy !== 1'b1; i++) @(posedge pclk);
    if (i == 60) timeout;
    sp = insn_suspend;
    for (n = 0; n < 40 && fetch_start !== 1'b1; n++) @(posedge pclk);
    if (n == 40) timeout;
    ff = fetch_fast;
  endtask
  task t_gate;
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    apb(1'b1, ADDR_FLAG, 32'h0000_0040);
    mreq_go(1'b1, 3'h3, 1'b1);
    repeat (20) @(posedge pclk);
    check(busy, 32'h0);
    mreq_go(1'b1, 3'h4, 1'b1);
    entry;
    check(n, CYC_FAST);
    check(sp, 32'h0);
    check(ff, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd & 32'h7, 32'h4);
    apb(1'b0, ADDR_FLAG, 32'h0);
    check(rd & 32'h64, 32'h0);
    apb(1'b0, ADDR_FSAVE, 32'h0);
    check(rd, 32'h40);
    mreq_go(1'b1, 3'h7, 1'b0);
    repeat (20) @(posedge pclk);
    check(busy, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0007);
    apb(1'b1, ADDR_FLAG, 32'h0000_0040);
    repeat (20) @(posedge pclk);
    check(busy, 32'h0);
    mreq_go(1'b1, 3'h1, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    entry;
    check(n, CYC_PERI_E16);
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], er}, 32'h1);
  endtask
  task t_src;
    static iesq_kind_t ks [7] = '{IESQ_SWINT, IESQ_SWINT, IESQ_NMI, IESQ_OVF,
                                  IESQ_BRKV, IESQ_SSTEP, IESQ_BRKF};
    static logic [4:0] e16 [7] = '{CYC_SWINT_E16, CYC_SWINT_OTH, CYC_FIX_16, CYC_OVF_16,
                                   CYC_BRKV_E16, CYC_DBG_16, CYC_DBG_16};
    static logic [4:0] e8 [7] = '{CYC_SWINT_OTH, CYC_SWINT_OTH, CYC_FIX_8, CYC_OVF_8,
                                  CYC_BRKV_OTH, CYC_DBG_8, CYC_DBG_8};
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, ADDR_CTRL, b ? 32'h0000_0008 : 32'h0);
      for (int i = 0; i < 7; i++) begin
        src_go(ks[i], 6'h28, i == 1);
        entry;
        check(n, b ? e8[i] : e16[i]);
      end
    end
    apb(1'b1, ADDR_FLAG, 32'h0000_0020);
    src_go(IESQ_SWINT, 6'h28, 1'b0);
    entry;
    apb(1'b0, ADDR_FLAG, 32'h0);
    check(rd & 32'h20, 32'h20);
    src_go(IESQ_SWINT, 6'h05, 1'b0);
    entry;
    apb(1'b0, ADDR_FLAG, 32'h0);
    check(rd & 32'h20, 32'h0);
  endtask
  task t_str;
    apb(1'b1, ADDR_CTRL, 32'h0);
    str <= 1'b1;
    src_go(IESQ_NMI, 6'h00, 1'b0);
    entry;
    check(n, CYC_FIX_16);
    check(sp, 32'h1);
    str <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
    check(rd[15:8] <= 8'h18, 32'h1);
    // Holding the boundary off past the bound must trip the wait monitor
    stall <= 1'b1;
    src_go(IESQ_NMI, 6'h00, 1'b0);
    repeat (30) @(posedge pclk);
    stall <= 1'b0;
    entry;
    check(n, CYC_FIX_16);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd & 32'h2, 32'h2);
    check(rd[15:8] > 8'h18, 32'h1);
    apb(1'b1, ADDR_STAT, 32'h0000_0002);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_gate;
    t_src;
    t_str;
    stop_test;
  end
endmodule // interrupt_entry_sequencer_test
`default_nettype wire
